// file: hdl/mmsd_top.sv
// The APB register port and the address map are this design's own decisions.
`default_nettype none
// Function
// - pins 2 and 7 at opposite levels
// - pin2 high: bridge 4,8,3 gives 1,2,4
// - pin7 high: bridge 8,4,3 gives 3,5,6
// - 10 min timeout, 100 h in 2,4
// - restart interlock active in every mode
// - contactor monitoring only in 1,2,3,5
// - pin 3 low enables contactor monitoring
// - timeout extension only in 1,5,6
// - muting-enable mode 5; partial mode 6 pairs
// - 5-pin: timing 2-sensor, sequence in 3,4
// - 8-pin: timing 4-sensor, sequence in 3,4
// - start button on pin 1 restarts
// - pin 4 carries second muting signal in 2,3,4,6
// - restart interlock permanently active
module mmsd_top #(
  parameter int unsigned TICK_CYCLES = mmsd_pkg::TICK_CYC,       // cycles per ms tick
  parameter int unsigned TMO_SHORT   = mmsd_pkg::TMO_SHORT_TICKS, // short timeout, ticks
  parameter int unsigned TMO_LONG    = mmsd_pkg::TMO_LONG_TICKS   // long timeout, ticks
) (
  input  wire logic        core_clk,          // core clock, 40 MHz
  input  wire logic        reset_n,           // async reset, low
  input  wire logic        clk_en,            // freezes all state when low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  input  wire logic [7:0]  plug_pin_in,       // plug pins 1..8 levels
  output logic             plug_pin1_out,     // pin 1 strap drive level
  output logic             plug_pin1_oe,      // pin 1 driven while high
  input  wire logic        eight_pin_variant, // strap: 8-pin receiver
  input  wire logic        transceiver,       // strap: transceiver system
  input  wire logic        muting_active,     // muting in progress
  output logic [2:0]       mode,              // selected muting mode
  output logic             cfg_lockout,       // wiring invalid, locked
  output logic             restart_interlock, // restart interlock on
  output logic             restart_cmd,       // one-cycle restart pulse
  output logic             seq_controlled,    // sequence controlled muting
  output logic             four_sensor,       // four sensor muting
  output logic             timeout_long,      // 100 h timeout selected
  output logic             contactor_feedback_monitor, // monitoring on
  output logic             tox_available,     // extension input offered
  output logic             muting_enable_mode, // muting-enable active
  output logic             partial_muting,    // partial muting active
  output logic             second_muting_input,     // second muting level
  output logic             timeout_extension_input, // extension level
  output logic             muting_expired,    // timeout hit, sticky
  output logic             safety_off         // safety outputs forced off
);
  // pin synchroniser, two flops per pin
  logic [7:0] sync_a;                      // first stage, read only by sync_b
  logic [7:0] sync_b;                      // usable pin levels

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      // each pin crosses on its own; the plug is asynchronous to core_clk
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else if (clk_en) begin
          sync_a[gi] <= plug_pin_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // strap state and samples
  mmsd_pkg::mmsd_state_e           state;       // strap sequencer
  mmsd_pkg::mmsd_state_e           next_state;  // sequencer next
  logic [mmsd_pkg::SETTLE_W-1:0]   settle;      // settle counter
  logic [7:0]                      samp_hi;     // pins with pin 1 high
  logic [7:0]                      samp_lo;     // pins with pin 1 low
  logic                            var8;        // variant latched once
  logic                            xcvr;        // transceiver latched once
  logic                            pin1_q;      // pin 1 level last cycle
  logic                            clr_req;     // software expiry clear
  logic [mmsd_pkg::CNT_W-1:0]      elapsed;     // timer count
  logic                            expire;      // timer expiry pulse

  wire settle_done = (settle == mmsd_pkg::SETTLE_W'(mmsd_pkg::STRAP_SETTLE_CYC - 1));

  // a bridged pin follows pin 1 both ways; a pin merely tied high does not
  wire f3 = samp_hi[mmsd_pkg::PIN3] & ~samp_lo[mmsd_pkg::PIN3];
  wire f4 = samp_hi[mmsd_pkg::PIN4] & ~samp_lo[mmsd_pkg::PIN4];
  wire f8 = samp_hi[mmsd_pkg::PIN8] & ~samp_lo[mmsd_pkg::PIN8];
  wire one_bridge = ({1'b0, f3} + {1'b0, f4} + {1'b0, f8}) == 2'd1;

  // supply side from pins 2 and 7, taken from the high phase
  wire p2     = samp_hi[mmsd_pkg::PIN2];
  wire p7     = samp_hi[mmsd_pkg::PIN7];
  wire side_a = p2 & ~p7;
  wire side_b = ~p2 & p7;

  // mode decode; any other combination yields no mode
  wire [2:0] dec_mode =
    !one_bridge    ? mmsd_pkg::MODE_NONE :
    (side_a && f4) ? mmsd_pkg::MODE_1 :
    (side_a && f8) ? mmsd_pkg::MODE_2 :
    (side_a && f3) ? mmsd_pkg::MODE_4 :
    (side_b && f8) ? mmsd_pkg::MODE_3 :
    (side_b && f4) ? mmsd_pkg::MODE_5 :
    (side_b && f3) ? mmsd_pkg::MODE_6 :
    mmsd_pkg::MODE_NONE;

  // per-mode features from the latched mode
  wire m1 = (mode == mmsd_pkg::MODE_1);
  wire m2 = (mode == mmsd_pkg::MODE_2);
  wire m3 = (mode == mmsd_pkg::MODE_3);
  wire m4 = (mode == mmsd_pkg::MODE_4);
  wire m5 = (mode == mmsd_pkg::MODE_5);
  wire m6 = (mode == mmsd_pkg::MODE_6);
  wire run = (state == mmsd_pkg::ST_RUN);

  wire f_long    = m2 | m4;
  wire f_seq     = m3 | m4;
  wire f_four    = var8 & (m1 | m2 | m5 | m6);
  wire f_cfm_ok  = m1 | m2 | m3 | m5;
  wire f_cfm     = f_cfm_ok & ~sync_b[mmsd_pkg::PIN3];
  wire f_tox     = m1 | m5 | m6;
  wire f_men     = m5;
  wire f_part    = m6 & ~xcvr;
  // pin 4 is free for the second signal whenever it is not the bridge
  wire f_sec     = m2 | m3 | m4 | m6;
  wire tox_level = f_tox & sync_b[mmsd_pkg::PIN8];
  wire pin1_rise = run & sync_b[mmsd_pkg::PIN1] & ~pin1_q;

  wire [mmsd_pkg::CNT_W-1:0] limit = f_long ? mmsd_pkg::CNT_W'(TMO_LONG)
                                            : mmsd_pkg::CNT_W'(TMO_SHORT);

  // sequencer: drive pin 1 high, then low, then judge the bridge once
  always_comb begin
    next_state = state;
    case (state)
      mmsd_pkg::ST_DRV_HI: begin
        if (settle_done) begin
          next_state = mmsd_pkg::ST_DRV_LO;
        end
      end
      mmsd_pkg::ST_DRV_LO: begin
        if (settle_done) begin
          next_state = mmsd_pkg::ST_DECIDE;
        end
      end
      mmsd_pkg::ST_DECIDE: begin
        // unknown wiring never falls back to a guessed mode
        next_state = (dec_mode == mmsd_pkg::MODE_NONE) ? mmsd_pkg::ST_LOCK
                                                       : mmsd_pkg::ST_RUN;
      end
      mmsd_pkg::ST_RUN:  next_state = mmsd_pkg::ST_RUN;  // no resampling after power-up
      mmsd_pkg::ST_LOCK: next_state = mmsd_pkg::ST_LOCK; // only reset leaves lockout
      default:           next_state = mmsd_pkg::ST_LOCK;
    endcase
  end

  // sequencer state and settle counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state  <= mmsd_pkg::ST_DRV_HI;
      settle <= '0;
    end else if (clk_en) begin
      state  <= next_state;
      settle <= (next_state != state) ? '0 : settle + 1'b1;
    end
  end

  // samples taken at the end of each settle phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_hi <= '0;
      samp_lo <= '0;
    end else if (clk_en && settle_done) begin
      if (state == mmsd_pkg::ST_DRV_HI) begin
        samp_hi <= sync_b;
      end
      if (state == mmsd_pkg::ST_DRV_LO) begin
        samp_lo <= sync_b;
      end
    end
  end

  // mode and straps latched once when the bridge is judged
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= mmsd_pkg::MODE_NONE;
      var8 <= 1'b0;
      xcvr <= 1'b0;
    end else if (clk_en && state == mmsd_pkg::ST_DECIDE) begin
      mode <= dec_mode;
      var8 <= eight_pin_variant;
      xcvr <= transceiver;
    end
  end

  // pin 1 drive: strap test levels only, then released to the start button
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      plug_pin1_out <= 1'b0;
      plug_pin1_oe  <= 1'b0;
    end else if (clk_en) begin
      plug_pin1_out <= (next_state == mmsd_pkg::ST_DRV_HI);
      plug_pin1_oe  <= (next_state == mmsd_pkg::ST_DRV_HI) ||
                       (next_state == mmsd_pkg::ST_DRV_LO);
    end
  end

  // feature outputs, all forced to their safe value until a mode runs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_lockout                <= 1'b0;
      restart_interlock          <= 1'b1;
      seq_controlled             <= 1'b0;
      four_sensor                <= 1'b0;
      timeout_long               <= 1'b0;
      contactor_feedback_monitor <= 1'b0;
      tox_available              <= 1'b0;
      muting_enable_mode         <= 1'b0;
      partial_muting             <= 1'b0;
      second_muting_input        <= 1'b0;
      timeout_extension_input    <= 1'b0;
      restart_cmd                <= 1'b0;
      pin1_q                     <= 1'b0;
    end else if (clk_en) begin
      cfg_lockout                <= (state == mmsd_pkg::ST_LOCK);
      restart_interlock          <= 1'b1;
      seq_controlled             <= run & f_seq;
      four_sensor                <= run & f_four;
      timeout_long               <= run & f_long;
      contactor_feedback_monitor <= run & f_cfm;
      tox_available              <= run & f_tox;
      muting_enable_mode         <= run & f_men;
      partial_muting             <= run & f_part;
      second_muting_input        <= run & f_sec & sync_b[mmsd_pkg::PIN4];
      timeout_extension_input    <= run & tox_level;
      restart_cmd                <= pin1_rise;
      pin1_q                     <= sync_b[mmsd_pkg::PIN1];
    end
  end

  // muting duration, only counted in a running mode
  mmsd_mute_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .active   (run & muting_active),
    .hold     (tox_level),
    .limit    (limit),
    .elapsed  (elapsed),
    .expire   (expire)
  );

  // expiry is sticky; a new expiry beats a clear in the same cycle
  wire exp_clear = clr_req | (restart_cmd & ~muting_active);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      muting_expired <= 1'b0;
      safety_off     <= 1'b1;
    end else if (clk_en) begin
      muting_expired <= expire | (muting_expired & ~exp_clear);
      safety_off     <= !run || expire || (muting_expired && !exp_clear);
    end
  end

  // apb decode
  wire acc      = psel & penable & ~pready;   // one wait state per access
  wire hit_st   = (paddr == mmsd_pkg::REG_STATUS);
  wire hit_ctl  = (paddr == mmsd_pkg::REG_CTRL);
  wire hit_el   = (paddr == mmsd_pkg::REG_ELAPSED);
  wire mapped   = hit_st | hit_ctl | hit_el;

  // status word built from the registered outputs
  wire [31:0] st_word = {19'h0, run, partial_muting, muting_enable_mode,
                         tox_available, contactor_feedback_monitor, four_sensor,
                         seq_controlled, timeout_long, muting_expired,
                         cfg_lockout, mode};
  wire [31:0] rd_word = hit_st ? st_word :
                        hit_el ? {3'h0, elapsed} : mmsd_pkg::RST_WORD;

  // apb answer: ready one cycle into the access phase, error if unmapped
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= mmsd_pkg::RST_WORD;
      clr_req <= 1'b0;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= (acc & ~pwrite) ? rd_word : mmsd_pkg::RST_WORD;
      // control bit self-clears, so it reads back as zero
      clr_req <= acc & pwrite & hit_ctl & pwdata[mmsd_pkg::CTRL_CLR];
    end
  end
endmodule
`default_nettype wire

// file: hdl/mmsd_pkg.sv
`default_nettype none
// shared constants of the muting mode strap decoder
package mmsd_pkg;
  // clock rate and timing figures
  localparam int unsigned CLK_MHZ          = 40;          // core clock in MHz
  localparam int unsigned STRAP_SETTLE_US  = 10;          // settle time per strap phase
  localparam int unsigned STRAP_SETTLE_CYC = STRAP_SETTLE_US * CLK_MHZ;
  localparam int unsigned TICK_MS          = 1;           // timer resolution in ms
  localparam int unsigned TICK_CYC         = TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned TMO_SHORT_MIN    = 10;          // short muting timeout, minutes
  localparam int unsigned TMO_LONG_H       = 100;         // long muting timeout, hours
  localparam int unsigned TMO_SHORT_TICKS  = TMO_SHORT_MIN * 60 * 1000 / TICK_MS;
  localparam int unsigned TMO_LONG_TICKS   = TMO_LONG_H * 3600 * 1000 / TICK_MS;
  localparam int          CNT_W            = 29;          // timeout counter width
  localparam int          SETTLE_W         = 9;           // settle counter width
  localparam int          PRE_W            = 16;          // tick prescaler width

  // plug pin positions in the pin vector (pin n sits at index n-1)
  localparam int PIN1 = 0;
  localparam int PIN2 = 1;
  localparam int PIN3 = 2;
  localparam int PIN4 = 3;
  localparam int PIN7 = 6;
  localparam int PIN8 = 7;

  // register offsets (byte addresses)
  localparam logic [11:0] REG_STATUS  = 12'h000;
  localparam logic [11:0] REG_CTRL    = 12'h004;
  localparam logic [11:0] REG_ELAPSED = 12'h008;

  // status field positions
  localparam int ST_MODE_LSB = 0;   // 3-bit mode
  localparam int ST_LOCKOUT  = 3;
  localparam int ST_EXPIRED  = 4;
  localparam int ST_TMO_LONG = 5;
  localparam int ST_SEQ      = 6;
  localparam int ST_FOUR     = 7;
  localparam int ST_CFM      = 8;
  localparam int ST_TOX      = 9;
  localparam int ST_MEN      = 10;
  localparam int ST_PARTIAL  = 11;
  localparam int ST_DONE     = 12;
  localparam int CTRL_CLR    = 0;   // write 1 clears expiry

  // mode codes and reset values
  localparam logic [2:0]  MODE_NONE = 3'h0;
  localparam logic [2:0]  MODE_1    = 3'h1;
  localparam logic [2:0]  MODE_2    = 3'h2;
  localparam logic [2:0]  MODE_3    = 3'h3;
  localparam logic [2:0]  MODE_4    = 3'h4;
  localparam logic [2:0]  MODE_5    = 3'h5;
  localparam logic [2:0]  MODE_6    = 3'h6;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

  // strap sampling sequence
  typedef enum logic [4:0] {
    ST_DRV_HI = 5'b00001,
    ST_DRV_LO = 5'b00010,
    ST_DECIDE = 5'b00100,
    ST_RUN    = 5'b01000,
    ST_LOCK   = 5'b10000
  } mmsd_state_e;
endpackage
`default_nettype wire

// file: hdl/mmsd_mute_timer.sv
`default_nettype none
// muting duration counter with ms prescaler
module mmsd_mute_timer #(
  parameter int unsigned TICK_CYCLES = mmsd_pkg::TICK_CYC
) (
  input  wire logic                       core_clk, // core clock
  input  wire logic                       reset_n,  // async reset, low
  input  wire logic                       clk_en,   // freezes state when low
  input  wire logic                       active,   // muting in progress
  input  wire logic                       hold,     // extension holds the count
  input  wire logic [mmsd_pkg::CNT_W-1:0] limit,    // timeout in ticks
  output logic      [mmsd_pkg::CNT_W-1:0] elapsed,  // ticks since muting began
  output logic                            expire    // pulse on reaching limit
);
  logic [mmsd_pkg::PRE_W-1:0] pre;   // cycle prescaler
  wire  tick    = (pre == mmsd_pkg::PRE_W'(TICK_CYCLES - 1));
  wire  at_lim  = (elapsed >= limit);
  wire  advance = active && tick && !hold && !at_lim;

  // prescaler restarts with every muting so the first tick is a full one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre <= '0;
    end else if (clk_en) begin
      pre <= (!active || tick) ? '0 : pre + 1'b1;
    end
  end

  // duration count, cleared when muting ends, saturates at the limit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      elapsed <= '0;
      expire  <= 1'b0;
    end else if (clk_en) begin
      elapsed <= !active ? '0 : (advance ? elapsed + 1'b1 : elapsed);
      expire  <= advance && (elapsed + 1'b1 == limit);
    end
  end
endmodule
`default_nettype wire

// file: testbench/mmsd_plug_model.sv
`default_nettype none
// plug wiring: static straps, one bridge to pin 1, start button
module mmsd_plug_model (
  input  wire logic       pin1_out, // device drive level on pin 1
  input  wire logic       pin1_oe,  // device drives pin 1
  input  wire logic [7:0] bridge,   // pins bridged to pin 1
  input  wire logic [7:0] level,    // static pin levels
  input  wire logic       button,   // start button switching +24 V
  output logic      [7:0] pins      // levels seen by the device
);
  timeunit 1ns;
  timeprecision 1ps;
  // released button leaves pin 1 on its pull-down
  assign pins[0] = pin1_oe ? pin1_out : button;
  // a bridge only shows while pin 1 is driven, so a stale strap cannot fake one
  for (genvar i = 1; i < 8; i++) begin : g_pin
    assign pins[i] = (bridge[i] && pin1_oe) ? pin1_out : level[i];
  end
endmodule
`default_nettype wire

// file: testbench/mmsd_top_assertions.sv
`default_nettype none
// output relations of the strap decoder
module mmsd_top_assertions (
  input wire logic       core_clk,                   // core clock
  input wire logic       reset_n,                    // async reset, low
  input wire logic       eight_pin_variant,          // 8-pin strap
  input wire logic       transceiver,                // transceiver strap
  input wire logic [2:0] mode,                       // decoded mode
  input wire logic       cfg_lockout,                // bad wiring
  input wire logic       restart_interlock,          // interlock on
  input wire logic       restart_cmd,                // restart pulse
  input wire logic       seq_controlled,             // sequence muting
  input wire logic       four_sensor,                // four sensors
  input wire logic       timeout_long,               // 100 h timeout
  input wire logic       contactor_feedback_monitor, // monitoring on
  input wire logic       tox_available,              // extension offered
  input wire logic       muting_enable_mode,         // muting-enable
  input wire logic       partial_muting,             // partial muting
  input wire logic       muting_expired,             // timeout hit
  input wire logic       safety_off                  // outputs off
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_interlock; restart_interlock; endproperty
  a_interlock: assert property (p_interlock) else $error("interlock low");
  property p_lockout; cfg_lockout |-> mode == 3'h0 && safety_off; endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not safe");
  property p_hold; mode != 3'h0 |=> $stable(mode); endproperty
  a_hold: assert property (p_hold) else $error("mode changed");
  // feature outputs are registered from the latched mode, so they trail it by one cycle
  property p_tmo; timeout_long == ($past(mode) == 3'h2 || $past(mode) == 3'h4); endproperty
  a_tmo: assert property (p_tmo) else $error("timeout choice wrong");
  property p_type; seq_controlled == ($past(mode) inside {3'h3, 3'h4}) &&
    four_sensor == ($past(mode) != 3'h0 && !seq_controlled && eight_pin_variant); endproperty
  a_type: assert property (p_type) else $error("muting type wrong");
  property p_cfm; contactor_feedback_monitor |-> mode inside {3'h1, 3'h2, 3'h3, 3'h5}; endproperty
  a_cfm: assert property (p_cfm) else $error("monitoring in wrong mode");
  property p_tox; tox_available == ($past(mode) inside {3'h1, 3'h5, 3'h6}); endproperty
  a_tox: assert property (p_tox) else $error("extension offer wrong");
  property p_men; muting_enable_mode == ($past(mode) == 3'h5) &&
    partial_muting == ($past(mode) == 3'h6 && !transceiver); endproperty
  a_men: assert property (p_men) else $error("enable or partial wrong");
  property p_restart; restart_cmd |-> mode != 3'h0 ##1 !restart_cmd; endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_expire; muting_expired |-> safety_off; endproperty
  a_expire: assert property (p_expire) else $error("expiry left outputs on");
endmodule
bind mmsd_top mmsd_top_assertions chk_i (.core_clk, .reset_n, .eight_pin_variant, .transceiver,
  .mode, .cfg_lockout, .restart_interlock, .restart_cmd, .seq_controlled, .four_sensor,
  .timeout_long, .contactor_feedback_monitor, .tox_available, .muting_enable_mode,
  .partial_muting, .muting_expired, .safety_off);
`default_nettype wire

// file: testbench/test_mmsd_top.sv
`default_nettype none
// straps every mode and two bad wirings, then times out muting and restarts
module test_mmsd_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCK = 4; // shortened ms tick
  localparam int TSH = 5; // short timeout, ticks
  localparam int TLG = 9; // long timeout, ticks
  logic        core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1; // clock, reset, enable
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;     // apb request
  logic [11:0] paddr = 12'h000;                                // apb address
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;             // apb data
  logic        pready, pslverr, er;                            // apb answer
  logic [7:0]  plug_pin_in, bridge = 8'h00, level = 8'h00;     // plug wiring
  logic        plug_pin1_out, plug_pin1_oe, button = 1'b0;     // pin 1 sides
  logic        eight_pin_variant = 1'b0, transceiver = 1'b0, muting_active = 1'b0; // straps
  logic [2:0]  mode;                                           // decoded mode
  logic        cfg_lockout, restart_interlock, restart_cmd, seq_controlled, four_sensor;
  logic        timeout_long, contactor_feedback_monitor, tox_available, muting_enable_mode;
  logic        partial_muting, second_muting_input, timeout_extension_input;
  logic        muting_expired, safety_off;                     // timer results
  int          n_errors = 0, num_checks = 0;                   // verdict counters

  always #12.5 core_clk = ~core_clk;

  mmsd_top #(.TICK_CYCLES(TCK), .TMO_SHORT(TSH), .TMO_LONG(TLG)) uut (
    .core_clk, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .plug_pin_in, .plug_pin1_out, .plug_pin1_oe, .eight_pin_variant, .transceiver,
    .muting_active, .mode, .cfg_lockout, .restart_interlock, .restart_cmd, .seq_controlled,
    .four_sensor, .timeout_long, .contactor_feedback_monitor, .tox_available,
    .muting_enable_mode, .partial_muting, .second_muting_input, .timeout_extension_input,
    .muting_expired, .safety_off);
  mmsd_plug_model plug (.pin1_out(plug_pin1_out), .pin1_oe(plug_pin1_oe), .bridge, .level,
    .button, .pins(plug_pin_in));

  // verdict and the one place the run ends
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare and report at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  // a used-up wait counts as a mismatch and ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("[ERR] wait exp below %0d got %0d", lim, n);
      end_of_test;
    end
  endtask

  // one apb transfer; an idle cycle follows so psel never toggles in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    bound(n, 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // k 0..5 modes 1..6, 6 both supplies high, 7 no bridge, 8 mode 6 transceiver
  task automatic run_case(input int k);
    logic [2:0]  m;
    logic [31:0] e;
    logic        hi2, p3;
    int          n, lim;
    m = (k < 6) ? 3'(k + 1) : (k == 8) ? 3'h6 : 3'h0;
    hi2 = (m inside {3'h1, 3'h2, 3'h4}) || k == 6;
    p3 = k[1];
    bridge <= (m inside {3'h1, 3'h5} || k == 6) ? 8'h08 : (m inside {3'h2, 3'h3}) ? 8'h80 :
              (m inside {3'h4, 3'h6}) ? 8'h04 : 8'h00;
    level <= {1'b1, !hi2 || k == 6, 2'b00, 1'b1, p3, hi2, 1'b0};
    eight_pin_variant <= k[0];
    transceiver <= (k == 8);
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    n = 0;
    while (plug_pin1_oe !== 1'b0 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    bound(n, 1000);
    repeat (2) @(posedge core_clk); // mode latches first, the feature flops one cycle later
    e = 32'(m);
    e[mmsd_pkg::ST_LOCKOUT] = (m == 3'h0);
    e[mmsd_pkg::ST_TMO_LONG] = m inside {3'h2, 3'h4};
    e[mmsd_pkg::ST_SEQ] = m inside {3'h3, 3'h4};
    e[mmsd_pkg::ST_FOUR] = k[0] && m != 3'h0 && !e[mmsd_pkg::ST_SEQ];
    e[mmsd_pkg::ST_CFM] = !p3 && m inside {3'h1, 3'h2, 3'h3, 3'h5};
    e[mmsd_pkg::ST_TOX] = m inside {3'h1, 3'h5, 3'h6};
    e[mmsd_pkg::ST_MEN] = (m == 3'h5);
    e[mmsd_pkg::ST_PARTIAL] = (m == 3'h6) && k != 8;
    e[mmsd_pkg::ST_DONE] = (m != 3'h0);
    chk("outputs", 32'(e[11:0]), 32'({partial_muting, muting_enable_mode, tox_available,
        contactor_feedback_monitor, four_sensor, seq_controlled, timeout_long,
        muting_expired, cfg_lockout, mode}));
    chk("side", 32'({1'b1, m == 3'h0, m inside {3'h2, 3'h3, 3'h4, 3'h6}, m inside {3'h1, 3'h5, 3'h6}}),
        32'({restart_interlock, safety_off, second_muting_input, timeout_extension_input}));
    apb(1'b0, mmsd_pkg::REG_STATUS, 32'h0, rd, er);
    chk("status", e, rd);
    if (m != 3'h0) begin
      level[7] <= 1'b0; // extension released so the count runs
      muting_active <= 1'b1;
      lim = e[mmsd_pkg::ST_TMO_LONG] ? TLG : TSH;
      n = 0;
      while (muting_expired !== 1'b1 && n < 200) begin
        @(posedge core_clk);
        n++;
      end
      bound(n, 200);
      chk("expire_at", 32'h1, 32'(n >= (lim - 1) * TCK && n <= lim * TCK + 8));
      chk("safety_off", 32'h1, 32'(safety_off));
      apb(1'b0, mmsd_pkg::REG_ELAPSED, 32'h0, rd, er);
      chk("elapsed", 32'(lim), rd);
      muting_active <= 1'b0;
      apb(1'b1, mmsd_pkg::REG_CTRL, 32'h1, rd, er);
      apb(1'b0, mmsd_pkg::REG_STATUS, 32'h0, rd, er);
      chk("cleared", e, rd);
      button <= 1'b1;
      for (int f = 0; f < 2; f++) begin
        clk_en <= (f == 1); // first pass frozen, so the press must go unseen
        n = 0;
        repeat (8) begin
          @(posedge core_clk);
          n += int'(restart_cmd);
        end
        chk("restart", 32'(f), 32'(n));
      end
      button <= 1'b0;
    end
  endtask

  initial begin
    for (int k = 0; k < 9; k++) run_case(k);
    apb(1'b0, 12'hffc, 32'h0, rd, er);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_data", 32'h0, rd);
    end_of_test;
  end
endmodule
`default_nettype wire
